/* hw/cfd_cfg.svh */
`ifndef CFD_CFG_SVH
`define CFD_CFG_SVH

// Oscillator select codes.
`define CFD_OSC_FAST         3'h0
`define CFD_OSC_FAST_PLL     3'h1
`define CFD_OSC_PRI          3'h2
`define CFD_OSC_PRI_PLL      3'h3
`define CFD_OSC_RESERVED     3'h4
`define CFD_OSC_LOWP         3'h5
`define CFD_OSC_FAST_D16     3'h6
`define CFD_OSC_FAST_DN      3'h7

// Primary oscillator mode codes.
`define CFD_POSC_EXT         2'h0
`define CFD_POSC_STD         2'h1
`define CFD_POSC_HSPD        2'h2
`define CFD_POSC_OFF         2'h3

// Debug channel codes.
`define CFD_DBG_RESERVED     2'h0
`define CFD_DBG_PAIR3        2'h1
`define CFD_DBG_PAIR2        2'h2
`define CFD_DBG_PAIR1        2'h3

// Timeout prescale ratios as log2.
`define CFD_PRE_LOG2_SMALL   3'h5
`define CFD_PRE_LOG2_LARGE   3'h7

// Window fraction in eighths of the period.
`define CFD_WIN_EIGHTHS_11   4'h2
`define CFD_WIN_EIGHTHS_10   4'h3
`define CFD_WIN_EIGHTHS_01   4'h4
`define CFD_WIN_EIGHTHS_00   4'h6

// Capture sequencing: cycles after reset release before fields are taken.
`define CFD_LOAD_DELAY       4'h2

`endif

/* hw/cfd_pkg.sv */
package cfd_pkg;

    // Raw fuse fields as presented by nonvolatile storage.
    typedef struct packed {
        logic       code_protect_n;
        logic       write_protect_n;
        logic       two_speed_startup;
        logic       waveform_reg_lock;
        logic [2:0] osc_select;
        logic [1:0] clock_switch_mode;
        logic       remap_once_lock;
        logic       second_osc_pin_pin_function;
        logic [1:0] primary_osc_mode;
        logic       timeout_always_on;
        logic       timeout_window_disable;
        logic       pll_lock_enable;
        logic       timeout_prescale_sel;
        logic [3:0] timeout_postscale_sel;
        logic [1:0] timeout_window_size;
        logic       twowire_port1_pin_sel;
        logic       twowire_port2_pin_sel;
        logic       boundary_scan_enable;
        logic [1:0] debug_channel_sel;
    } cfd_fuse_s;

    typedef enum logic [2:0] {
        CFD_CLK_FAST,
        CFD_CLK_FAST_PLL,
        CFD_CLK_PRI,
        CFD_CLK_PRI_PLL,
        CFD_CLK_LOWP,
        CFD_CLK_FAST_D16,
        CFD_CLK_FAST_DN,
        CFD_CLK_INVALID
    } cfd_clk_src_e;

    typedef enum logic [2:0] {
        CFD_POSC_MODE_EXT,
        CFD_POSC_MODE_STD,
        CFD_POSC_MODE_HSPD,
        CFD_POSC_MODE_OFF
    } cfd_posc_e;

    // Clock unit controls.
    typedef struct packed {
        cfd_clk_src_e start_src;
        cfd_clk_src_e target_src;
        logic         auto_switch;
        logic         switch_enable;
        logic         fail_safe_enable;
        cfd_posc_e    posc_mode;
        logic         posc_enable;
        logic         pin2_clock_out;
        logic         pin2_gpio;
        logic         pll_lock_enable;
        logic         osc_code_bad;
    } cfd_clk_ctl_s;

    // Timeout unit controls.
    typedef struct packed {
        logic       force_on;
        logic       sw_can_stop;
        logic       windowed;
        logic [2:0] pre_log2;
        logic [3:0] post_log2;
        logic [3:0] window_eighths;
    } cfd_tmo_ctl_s;

    // Protection, remap and debug controls.
    typedef struct packed {
        logic       read_block;
        logic       write_block;
        logic       waveform_key_needed;
        logic       remap_once;
        logic       twowire1_alt;
        logic       twowire2_alt;
        logic       scan_enable;
        logic       tms_pullup;
        logic [2:0] debug_pair_onehot;
        logic       debug_code_bad;
    } cfd_sys_ctl_s;

endpackage

/* hw/cfd_osc_decode.sv */
`timescale 1ns/1ps
`include "cfd_cfg.svh"

module cfd_osc_decode (
    // Raw fields.
    input  wire logic [2:0]          osc_select,
    input  wire logic [1:0]          primary_osc_mode,
    input  wire logic                two_speed_startup,
    input  wire logic [1:0]          clock_switch_mode,
    input  wire logic                second_osc_pin_pin_function,
    input  wire logic                pll_lock_enable,
    // Decoded clock controls.
    output cfd_pkg::cfd_clk_ctl_s    clk_ctl
);
    import cfd_pkg::*;

    // =====================================================================
    // Oscillator source decode
    // =====================================================================
    function automatic cfd_clk_src_e src_of(input logic [2:0] code);
        case (code)
            `CFD_OSC_FAST:      src_of = CFD_CLK_FAST;
            `CFD_OSC_FAST_PLL:  src_of = CFD_CLK_FAST_PLL;
            `CFD_OSC_PRI:       src_of = CFD_CLK_PRI;
            `CFD_OSC_PRI_PLL:   src_of = CFD_CLK_PRI_PLL;
            `CFD_OSC_LOWP:      src_of = CFD_CLK_LOWP;
            `CFD_OSC_FAST_D16:  src_of = CFD_CLK_FAST_D16;
            `CFD_OSC_FAST_DN:   src_of = CFD_CLK_FAST_DN;
            default:            src_of = CFD_CLK_INVALID;
        endcase
    endfunction

    // All controls come straight from fields; the caller registers them.
    always_comb begin
        clk_ctl             = '0;
        clk_ctl.target_src  = src_of(osc_select); // [RULE5]
        // A reserved code is the configuring party's fault; fall back to fast RC.
        clk_ctl.osc_code_bad = (osc_select == `CFD_OSC_RESERVED); // [RULE6]
        if (clk_ctl.osc_code_bad) begin
            clk_ctl.target_src = CFD_CLK_FAST;
        end
        clk_ctl.auto_switch = two_speed_startup; // [RULE3]
        clk_ctl.start_src   = two_speed_startup ? CFD_CLK_FAST : clk_ctl.target_src; // [RULE3]
        clk_ctl.switch_enable    = ~clock_switch_mode[1]; // [RULE7]
        clk_ctl.fail_safe_enable = (clock_switch_mode == 2'h0); // [RULE7]
        case (primary_osc_mode)
            `CFD_POSC_EXT: clk_ctl.posc_mode = CFD_POSC_MODE_EXT; // [RULE10]
            `CFD_POSC_STD:  clk_ctl.posc_mode = CFD_POSC_MODE_STD;
            `CFD_POSC_HSPD: clk_ctl.posc_mode = CFD_POSC_MODE_HSPD;
            default:       clk_ctl.posc_mode = CFD_POSC_MODE_OFF;
        endcase
        clk_ctl.posc_enable = (primary_osc_mode != `CFD_POSC_OFF); // [RULE10]
        // Crystal modes own the second pin, so neither function applies then.
        if ((primary_osc_mode == `CFD_POSC_STD) || (primary_osc_mode == `CFD_POSC_HSPD)) begin
            clk_ctl.pin2_clock_out = 1'b0;
            clk_ctl.pin2_gpio      = 1'b0;
        end else begin
            clk_ctl.pin2_clock_out = second_osc_pin_pin_function; // [RULE9]
            clk_ctl.pin2_gpio      = ~second_osc_pin_pin_function; // [RULE9]
        end
        clk_ctl.pll_lock_enable = pll_lock_enable; // [RULE14]
    end

endmodule

/* hw/cfd_tmo_decode.sv */
`timescale 1ns/1ps
`include "cfd_cfg.svh"

module cfd_tmo_decode (
    // Raw fields.
    input  wire logic                timeout_always_on,
    input  wire logic                timeout_window_disable,
    input  wire logic                timeout_prescale_sel,
    input  wire logic [3:0]          timeout_postscale_sel,
    input  wire logic [1:0]          timeout_window_size,
    // Decoded timeout controls.
    output cfd_pkg::cfd_tmo_ctl_s    tmo_ctl
);
    import cfd_pkg::*;

    // =====================================================================
    // Timeout scaling and window decode
    // =====================================================================
    always_comb begin
        tmo_ctl             = '0;
        tmo_ctl.force_on    = timeout_always_on; // [RULE11]
        tmo_ctl.sw_can_stop = ~timeout_always_on; // [RULE12]
        tmo_ctl.windowed    = ~timeout_window_disable; // [RULE13]
        tmo_ctl.pre_log2    = timeout_prescale_sel ? `CFD_PRE_LOG2_LARGE
                                                   : `CFD_PRE_LOG2_SMALL; // [RULE15]
        // Ratio is two to the field value, so the field is the log2 as is.
        tmo_ctl.post_log2   = timeout_postscale_sel; // [RULE16]
        case (timeout_window_size)
            2'h3:    tmo_ctl.window_eighths = `CFD_WIN_EIGHTHS_11; // [RULE17]
            2'h2:    tmo_ctl.window_eighths = `CFD_WIN_EIGHTHS_10;
            2'h1:    tmo_ctl.window_eighths = `CFD_WIN_EIGHTHS_01;
            default: tmo_ctl.window_eighths = `CFD_WIN_EIGHTHS_00;
        endcase
    end

endmodule

/* hw/cfd_top.sv */
// Contract
// [RULE1] Code-protect field 0 blocks protected reads of all program memory.
// [RULE2] Write-protect field 0 refuses writes to user program memory.
// [RULE3] Two-speed field 1 starts on fast RC, then switches to selected source.
// [RULE4] Waveform lock field 1 requires an unlock key before register writes.
// [RULE5] Oscillator select decodes seven codes into start-up clock sources.
// [RULE6] Configuring party never programs oscillator select code 100.
// [RULE7] Switch mode 1x disables all, 01 switching only, 00 both.
// [RULE8] Remap lock field 1 allows one remap; 0 allows repeated remaps.
// [RULE9] Outside crystal modes, field 1 gives clock out, 0 gives GPIO.
// [RULE10] Primary mode: 11 off, 10 high-speed, 01 standard, 00 external.
// [RULE11] Timeout enable field 1 forces unit and clock on permanently.
// [RULE12] Timeout enable field 0 lets the software bit start and stop it.
// [RULE13] Window-disable 0 gives windowed mode, 1 non-windowed.
// [RULE14] PLL lock feature follows its enable field.
// [RULE15] Prescaler divides by 128 when field is 1, else 32.
// [RULE16] Postscaler ratio is two raised to the four-bit field.
// [RULE17] Window size: 11 25%, 10 37.5%, 01 50%, 00 75%.
// [RULE18] Port 1 field 1 uses primary pins, 0 uses alternate pair.
// [RULE19] Port 2 field 0 uses alternate pair, 1 uses primary pins.
// [RULE20] Scan enable field 1 enables the port and the select-pin pull-up.
// [RULE21] Debug channel 11 pair one, 10 pair two, 01 pair three.
// [RULE22] Fields are captured at reset and held until the next reset.
`timescale 1ns/1ps
`include "cfd_cfg.svh"

module cfd_top (
    // Clock and reset.
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // Fuse words from nonvolatile storage.
    input  cfd_pkg::cfd_fuse_s       fuse_in,
    input  wire logic                fuse_valid,
    // Software enable of the timeout unit.
    input  wire logic                timeout_sw_enable,
    // Waveform unlock key seen by the waveform unit.
    input  wire logic                waveform_key_ok,
    // Remap write attempt from the pin-select unit.
    input  wire logic                remap_write_req,
    // Decoded controls.
    output cfd_pkg::cfd_clk_ctl_s    clk_ctl,
    output cfd_pkg::cfd_tmo_ctl_s    tmo_ctl,
    output cfd_pkg::cfd_sys_ctl_s    sys_ctl,
    // Live gating.
    output logic                     timeout_run,
    output logic                     lp_osc_run,
    output logic                     waveform_write_ok,
    output logic                     remap_write_ok,
    output logic                     cfg_loaded
);
    import cfd_pkg::*;

    // =====================================================================
    // State
    // =====================================================================
    typedef enum logic [1:0] {
        CFD_ST_WAIT,
        CFD_ST_LOAD,
        CFD_ST_HOLD
    } cfd_state_e;

    typedef struct packed {
        cfd_state_e   state;
        logic [3:0]   delay;
        cfd_fuse_s    fuse;
        cfd_clk_ctl_s clk;
        cfd_tmo_ctl_s tmo;
        cfd_sys_ctl_s sys;
        logic         remap_used;
        logic         loaded;
    } cfd_regs_s;

    cfd_regs_s    r_q;
    cfd_regs_s    r_d;
    cfd_clk_ctl_s clk_dec;
    cfd_tmo_ctl_s tmo_dec;

    // =====================================================================
    // Field decoders
    // =====================================================================
    cfd_osc_decode u_osc (
        .osc_select        (r_q.fuse.osc_select),
        .primary_osc_mode  (r_q.fuse.primary_osc_mode),
        .two_speed_startup (r_q.fuse.two_speed_startup),
        .clock_switch_mode (r_q.fuse.clock_switch_mode),
        .second_osc_pin_pin_function (r_q.fuse.second_osc_pin_pin_function),
        .pll_lock_enable   (r_q.fuse.pll_lock_enable),
        .clk_ctl           (clk_dec)
    );

    cfd_tmo_decode u_tmo (
        .timeout_always_on      (r_q.fuse.timeout_always_on),
        .timeout_window_disable (r_q.fuse.timeout_window_disable),
        .timeout_prescale_sel   (r_q.fuse.timeout_prescale_sel),
        .timeout_postscale_sel  (r_q.fuse.timeout_postscale_sel),
        .timeout_window_size    (r_q.fuse.timeout_window_size),
        .tmo_ctl                (tmo_dec)
    );

    // =====================================================================
    // Next state
    // =====================================================================
    // The fields are sampled once after reset release and never again, so a
    // glitch on the storage bus after start-up cannot alter the device.
    always_comb begin
        r_d = r_q;
        case (r_q.state)
            CFD_ST_WAIT: begin
                if (r_q.delay != 4'h0) begin
                    r_d.delay = r_q.delay - 4'h1;
                end else if (fuse_valid) begin
                    r_d.fuse  = fuse_in; // [RULE22]
                    r_d.state = CFD_ST_LOAD;
                end
            end
            CFD_ST_LOAD: begin
                r_d.clk = clk_dec;
                r_d.tmo = tmo_dec;
                r_d.sys.read_block          = ~r_q.fuse.code_protect_n; // [RULE1]
                r_d.sys.write_block         = ~r_q.fuse.write_protect_n; // [RULE2]
                r_d.sys.waveform_key_needed = r_q.fuse.waveform_reg_lock; // [RULE4]
                r_d.sys.remap_once          = r_q.fuse.remap_once_lock; // [RULE8]
                r_d.sys.twowire1_alt        = ~r_q.fuse.twowire_port1_pin_sel; // [RULE18]
                r_d.sys.twowire2_alt        = ~r_q.fuse.twowire_port2_pin_sel; // [RULE19]
                r_d.sys.scan_enable         = r_q.fuse.boundary_scan_enable; // [RULE20]
                r_d.sys.tms_pullup          = r_q.fuse.boundary_scan_enable; // [RULE20]
                case (r_q.fuse.debug_channel_sel)
                    `CFD_DBG_PAIR1: r_d.sys.debug_pair_onehot = 3'h1; // [RULE21]
                    `CFD_DBG_PAIR2: r_d.sys.debug_pair_onehot = 3'h2; // [RULE21]
                    `CFD_DBG_PAIR3: r_d.sys.debug_pair_onehot = 3'h4; // [RULE21]
                    default:        r_d.sys.debug_pair_onehot = 3'h0;
                endcase
                r_d.sys.debug_code_bad = (r_q.fuse.debug_channel_sel == `CFD_DBG_RESERVED);
                r_d.loaded = 1'b1;
                r_d.state  = CFD_ST_HOLD;
            end
            CFD_ST_HOLD: begin
                // A granted remap write uses up the single allowed change.
                if (remap_write_ok) begin
                    r_d.remap_used = 1'b1; // [RULE8]
                end
            end
            default: begin
                r_d.state = CFD_ST_WAIT;
            end
        endcase
    end

    // =====================================================================
    // State register
    // =====================================================================
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q.state      <= CFD_ST_WAIT;
            r_q.delay      <= `CFD_LOAD_DELAY;
            r_q.fuse       <= '1; // Erased storage reads as all ones.
            r_q.clk        <= '0;
            r_q.tmo        <= '0;
            // Protection stays on until real fields arrive; safer than open.
            r_q.sys        <= '0;
            r_q.sys.read_block  <= 1'b1;
            r_q.sys.write_block <= 1'b1;
            r_q.remap_used <= 1'b0;
            r_q.loaded     <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign clk_ctl    = r_q.clk;
    assign tmo_ctl    = r_q.tmo;
    assign sys_ctl    = r_q.sys;
    assign cfg_loaded = r_q.loaded;

    // Forced-on overrides software; otherwise software bit rules both.
    assign timeout_run = r_q.loaded & (r_q.tmo.force_on | timeout_sw_enable); // [RULE11] [RULE12]
    assign lp_osc_run  = timeout_run; // [RULE12]

    // Waveform writes pass freely unless the lock needs a key.
    assign waveform_write_ok = r_q.loaded &
                               (~r_q.sys.waveform_key_needed | waveform_key_ok); // [RULE4]

    // Remap writes pass unless the one-shot lock has already been spent.
    assign remap_write_ok = r_q.loaded & remap_write_req &
                            ~(r_q.sys.remap_once & r_q.remap_used); // [RULE8]

endmodule

/* test/cfd_fuse_store_model.sv */
`timescale 1ns/1ps

// ========
// Fuse storage model
module cfd_fuse_store_model (
    // Clock and reset.
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    // Word to present and read speed.
    input  cfd_pkg::cfd_fuse_s  word,
    input  wire logic           slow,
    input  wire logic           scramble,
    // Storage side of the loader.
    output cfd_pkg::cfd_fuse_s  fuse_in,
    output logic                fuse_valid
);
    import cfd_pkg::*;
    logic [2:0] cnt_q;
    cfd_fuse_s  prog;

    // Reserved oscillator code is never burned.
    always_comb begin
        prog = word;
        if (prog.osc_select == 3'h4) begin
            prog.osc_select = 3'h0;
        end
    end

    // Read latency after reset.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 3'h0;
        end else if (cnt_q != 3'h7) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // Invalid data is inverted so a stale capture fails.
    assign fuse_valid = !scramble && (cnt_q >= (slow ? 3'h6 : 3'h1));
    assign fuse_in    = fuse_valid ? prog : ~prog;
endmodule

/* test/cfd_top_asserts.sv */
`timescale 1ns/1ps

// ========
// Decoder port checks
module cfd_top_asserts (
    // Clock and reset.
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Decoder inputs.
    input  cfd_pkg::cfd_fuse_s    fuse_in,
    input  wire logic             timeout_sw_enable,
    input  wire logic             waveform_key_ok,
    // Decoder outputs.
    input  cfd_pkg::cfd_clk_ctl_s clk_ctl,
    input  cfd_pkg::cfd_tmo_ctl_s tmo_ctl,
    input  cfd_pkg::cfd_sys_ctl_s sys_ctl,
    input  wire logic             timeout_run,
    input  wire logic             lp_osc_run,
    input  wire logic             waveform_write_ok,
    input  wire logic             remap_write_ok,
    input  wire logic             cfg_loaded
);
    import cfd_pkg::*;
    // Single domain.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_loaded;
        $rose(cfg_loaded);
    endsequence
    sequence s_grant;
        remap_write_ok && sys_ctl.remap_once;
    endsequence

    property p_protect;
        s_loaded |-> sys_ctl.read_block == !fuse_in.code_protect_n
            && sys_ctl.write_block == !fuse_in.write_protect_n;
    endproperty
    a_protect: assert property (p_protect) else $error("protect wrong");
    property p_switch;
        s_loaded |-> clk_ctl.switch_enable == !fuse_in.clock_switch_mode[1]
            && clk_ctl.fail_safe_enable == (fuse_in.clock_switch_mode == 2'h0);
    endproperty
    a_switch: assert property (p_switch) else $error("switch wrong");
    property p_posc;
        s_loaded |-> clk_ctl.posc_enable == (fuse_in.primary_osc_mode != 2'h3);
    endproperty
    a_posc: assert property (p_posc) else $error("primary wrong");
    property p_scale;
        s_loaded |-> tmo_ctl.pre_log2 == (fuse_in.timeout_prescale_sel ? 3'h7 : 3'h5)
            && tmo_ctl.post_log2 == fuse_in.timeout_postscale_sel;
    endproperty
    a_scale: assert property (p_scale) else $error("scaler wrong");
    property p_window;
        s_loaded |-> tmo_ctl.windowed == !fuse_in.timeout_window_disable;
    endproperty
    a_window: assert property (p_window) else $error("window wrong");
    property p_scan;
        s_loaded |-> sys_ctl.scan_enable == fuse_in.boundary_scan_enable
            && sys_ctl.tms_pullup == fuse_in.boundary_scan_enable;
    endproperty
    a_scan: assert property (p_scan) else $error("scan wrong");
    property p_run;
        timeout_run == (cfg_loaded && (tmo_ctl.force_on || timeout_sw_enable))
            && lp_osc_run == timeout_run;
    endproperty
    a_run: assert property (p_run) else $error("run wrong");
    property p_wave;
        waveform_write_ok == (cfg_loaded && (!sys_ctl.waveform_key_needed || waveform_key_ok));
    endproperty
    a_wave: assert property (p_wave) else $error("wave gate wrong");
    property p_remap;
        s_grant |=> !remap_write_ok [*8];
    endproperty
    a_remap: assert property (p_remap) else $error("second remap");
    property p_hold;
        cfg_loaded |=> cfg_loaded && $stable(clk_ctl) && $stable(tmo_ctl) && $stable(sys_ctl);
    endproperty
    a_hold: assert property (p_hold) else $error("controls moved");
    c_grant: cover property (s_grant);
endmodule

bind cfd_top cfd_top_asserts u_asserts (
    .ref_clk(ref_clk), .rst_n(rst_n), .fuse_in(fuse_in),
    .timeout_sw_enable(timeout_sw_enable), .waveform_key_ok(waveform_key_ok),
    .clk_ctl(clk_ctl), .tmo_ctl(tmo_ctl),
    .sys_ctl(sys_ctl), .timeout_run(timeout_run), .lp_osc_run(lp_osc_run),
    .waveform_write_ok(waveform_write_ok), .remap_write_ok(remap_write_ok),
    .cfg_loaded(cfg_loaded)
);

/* test/config_fuse_decoder_tb.sv */
`timescale 1ns/1ps

// ========
// Decoder testbench
module config_fuse_decoder_tb;
    import cfd_pkg::*;
    logic         ref_clk;
    logic         rst_n = 1'b0;
    logic         slow = 1'b0;
    logic         scramble = 1'b0;
    logic         sw_en = 1'b0;
    logic         key_ok = 1'b0;
    logic         req = 1'b0;
    logic         fuse_valid;
    logic         timeout_run;
    logic         lp_osc_run;
    logic         wave_ok;
    logic         remap_ok;
    logic         cfg_loaded;
    cfd_fuse_s    word = '0;
    cfd_fuse_s    fuse_in;
    cfd_fuse_s    cur;
    cfd_clk_ctl_s clk_ctl;
    cfd_tmo_ctl_s tmo_ctl;
    cfd_sys_ctl_s sys_ctl;
    int           miscompares = 0;
    int           compares = 0;

    cfd_fuse_store_model u_store (.ref_clk(ref_clk), .rst_n(rst_n), .word(word),
        .slow(slow), .scramble(scramble), .fuse_in(fuse_in), .fuse_valid(fuse_valid));
    cfd_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .fuse_in(fuse_in),
        .fuse_valid(fuse_valid), .timeout_sw_enable(sw_en), .waveform_key_ok(key_ok),
        .remap_write_req(req), .clk_ctl(clk_ctl), .tmo_ctl(tmo_ctl), .sys_ctl(sys_ctl),
        .timeout_run(timeout_run), .lp_osc_run(lp_osc_run), .waveform_write_ok(wave_ok),
        .remap_write_ok(remap_ok), .cfg_loaded(cfg_loaded));

    // Free-running 100 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ========
    // Words and expectations
    // Index bits spread so every one- and two-bit field code appears across eight words.
    function automatic cfd_fuse_s mk(input int i);
        logic [2:0] b;
        logic [2:0] osc;
        b = i[2:0];
        osc = (i < 4) ? b : ((i == 7) ? 3'h2 : b + 3'h1);
        return '{b[0], b[1], b[2], b[0], osc, b[1:0], b[1], b[2] ^ b[0], b[1:0] + b[2],
            b[1], b[2], b[0], b[1], {b, b[0]}, ~b[1:0], b[2], !b[2], b[0] ^ b[1], b[1:0]};
    endfunction
    function automatic cfd_clk_ctl_s exp_clk(input cfd_fuse_s f);
        cfd_clk_src_e t;
        logic         xh;
        logic [1:0]   pm;
        pm = f.primary_osc_mode;
        xh = (pm == 2'h1) || (pm == 2'h2);
        case (f.osc_select)
            3'h1: t = CFD_CLK_FAST_PLL;
            3'h2: t = CFD_CLK_PRI;
            3'h3: t = CFD_CLK_PRI_PLL;
            3'h5: t = CFD_CLK_LOWP;
            3'h6: t = CFD_CLK_FAST_D16;
            3'h7: t = CFD_CLK_FAST_DN;
            default: t = CFD_CLK_FAST;
        endcase
        return '{f.two_speed_startup ? CFD_CLK_FAST : t, t, f.two_speed_startup,
            !f.clock_switch_mode[1], f.clock_switch_mode == 2'h0, cfd_posc_e'({1'b0, pm}),
            pm != 2'h3, f.second_osc_pin_pin_function && !xh, !f.second_osc_pin_pin_function && !xh,
            f.pll_lock_enable, 1'b0};
    endfunction
    function automatic cfd_tmo_ctl_s exp_tmo(input cfd_fuse_s f);
        logic [1:0] w;
        w = f.timeout_window_size;
        return '{f.timeout_always_on, !f.timeout_always_on, !f.timeout_window_disable,
            f.timeout_prescale_sel ? 3'h7 : 3'h5, f.timeout_postscale_sel,
            w == 2'h3 ? 4'h2 : (w == 2'h2 ? 4'h3 : (w == 2'h1 ? 4'h4 : 4'h6))};
    endfunction
    function automatic cfd_sys_ctl_s exp_sys(input cfd_fuse_s f);
        logic [1:0] d;
        d = f.debug_channel_sel;
        return '{!f.code_protect_n, !f.write_protect_n, f.waveform_reg_lock,
            f.remap_once_lock, !f.twowire_port1_pin_sel, !f.twowire_port2_pin_sel,
            f.boundary_scan_enable, f.boundary_scan_enable,
            d == 2'h3 ? 3'h1 : (d == 2'h2 ? 3'h2 : (d == 2'h1 ? 3'h4 : 3'h0)), d == 2'h0};
    endfunction

    // ========
    // Reporting
    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic bad(input string m);
        miscompares++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            bad(m);
        end
    endtask

    // ========
    // Scenarios
    // Reset held two cycles: protection on, nothing loaded.
    task automatic t_reset();
        @(posedge ref_clk) rst_n <= 1'b0;
        @(negedge ref_clk) chk(sys_ctl.read_block & sys_ctl.write_block, "rst prot");
        chk(!cfg_loaded && !timeout_run && !wave_ok, "rst out");
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask
    // Load one word and compare every decoded control.
    task automatic t_load(input int i);
        int n;
        cur = mk(i);
        @(posedge ref_clk) word <= cur;
        slow <= i[0];
        scramble <= 1'b0;
        t_reset();
        for (n = 0; n < 20 && cfg_loaded !== 1'b1; n++) @(posedge ref_clk);
        if (cfg_loaded !== 1'b1) begin
            bad("load timeout");
            summarize();
        end
        @(negedge ref_clk);
        chk(clk_ctl === exp_clk(cur), "clk");
        chk(tmo_ctl === exp_tmo(cur), "tmo");
        chk(sys_ctl === exp_sys(cur), "sys");
    endtask
    // Software enable matters only when not forced on.
    task automatic t_timeout();
        @(posedge ref_clk) sw_en <= 1'b0;
        @(negedge ref_clk) chk(timeout_run === cur.timeout_always_on, "off");
        chk(lp_osc_run === cur.timeout_always_on, "lp off");
        @(posedge ref_clk) sw_en <= 1'b1;
        @(negedge ref_clk) chk(timeout_run === 1'b1 && lp_osc_run === 1'b1, "on");
    endtask
    // Key needed only when locked.
    task automatic t_wave();
        @(posedge ref_clk) key_ok <= 1'b0;
        @(negedge ref_clk) chk(wave_ok === !cur.waveform_reg_lock, "wave no key");
        @(posedge ref_clk) key_ok <= 1'b1;
        @(negedge ref_clk) chk(wave_ok === 1'b1, "wave keyed");
    endtask
    // Second remap refused only when locked.
    task automatic t_remap();
        @(posedge ref_clk) req <= 1'b1;
        @(negedge ref_clk) chk(remap_ok === 1'b1, "first remap");
        @(posedge ref_clk) req <= 1'b0;
        @(negedge ref_clk) chk(remap_ok === 1'b0, "idle remap");
        @(posedge ref_clk) req <= 1'b1;
        @(negedge ref_clk) chk(remap_ok === !cur.remap_once_lock, "second remap");
        @(posedge ref_clk) req <= 1'b0;
    endtask
    // Storage turns invalid; controls must not follow.
    task automatic t_hold();
        @(posedge ref_clk) scramble <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(clk_ctl === exp_clk(cur) && tmo_ctl === exp_tmo(cur), "held");
        chk(sys_ctl === exp_sys(cur) && cfg_loaded === 1'b1, "hs");
    endtask

    // Each word is loaded by its own reset.
    initial begin
        for (int i = 0; i < 8; i++) begin
            t_load(i);
            t_timeout();
            t_wave();
            t_remap();
            t_hold();
        end
        summarize();
    end
endmodule
